/* File: rtl/motion_cmd_pkg.sv */
`default_nettype none
package motion_cmd_pkg;

    // Register width of the device and local address width on the bus.
    localparam int DATA_W = 24;
    localparam int ADDR_W = 8;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFS_CMD    = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_AXIS   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STAGE  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_LPOS   = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_PPOS   = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_STRIG  = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_PLIM   = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_MLIM   = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_GRP1   = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_GRP2   = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_SCMD   = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_ANSWER = 8'h2C;
    localparam logic [ADDR_W-1:0] OFS_PARAM  = 8'h30;

    // Field positions.
    localparam int CODE_MSB   = 20;
    localparam int CODE_LSB   = 16;
    localparam int SCODE_MSB  = 19;
    localparam int SLOT_MSB   = 12;
    localparam int SLOT_LSB   = 8;
    localparam int DOP_MSB    = 7;
    localparam int DOP_LSB    = 4;
    localparam int MOVING_BIT = 23;
    localparam int GUARD_MSB  = 7;
    localparam int GUARD_LSB  = 0;
    localparam int OUT2_SEL   = 0;
    localparam int ERR_LSB    = 24;

    // Command codes.
    localparam logic [4:0] CODE_CLEAR      = 5'h00;
    localparam logic [4:0] CODE_HALT       = 5'h01;
    localparam logic [4:0] CODE_LOW_RUN    = 5'h02;
    localparam logic [4:0] CODE_HOME_THREE = 5'h0F;
    localparam logic [4:0] CODE_MINUS_DIR  = 5'h11;
    localparam logic [4:0] CODE_OUT_WRITE  = 5'h12;
    localparam logic [4:0] CODE_LPOS_LOAD  = 5'h16;
    localparam logic [4:0] CODE_PPOS_LOAD  = 5'h17;
    localparam logic [4:0] CODE_STRIG_LOAD = 5'h18;
    localparam logic [4:0] CODE_PLIM_LOAD  = 5'h19;
    localparam logic [4:0] CODE_MLIM_LOAD  = 5'h1A;
    localparam logic [4:0] CODE_GRP1_LOAD  = 5'h1B;
    localparam logic [4:0] CODE_GRP2_LOAD  = 5'h1C;
    localparam logic [4:0] CODE_SLOT_READ  = 5'h1D;
    localparam logic [4:0] CODE_SLOT_WRITE = 5'h1E;
    localparam logic [4:0] CODE_FILE_SAVE  = 5'h1F;

    // Answer status and error codes.
    localparam logic [7:0] ANSWER_IDLE  = 8'h00;
    localparam logic [7:0] ANSWER_ERROR = 8'h3D;
    localparam logic [7:0] ERR_NONE     = 8'h00;
    localparam logic [7:0] ERR_MOVING   = 8'h02;
    localparam logic [7:0] ERR_SEQUENCE = 8'h40;

    // Reset value of every 24-bit data register.
    localparam logic [DATA_W-1:0] REG_RESET = 24'h000000;

    typedef enum logic [1:0] {
        PH_IDLE  = 2'b00,
        PH_WRITE = 2'b01,
        PH_READ  = 2'b11
    } bus_phase_e;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
    } bus_op_s;

    typedef struct packed {
        logic              start;
        logic [4:0]        code;
        logic [DATA_W-1:0] param;
    } motion_req_s;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       save;
        logic [4:0] slot;
    } profile_req_s;

    // Motion group, codes 0x01 to 0x11.
    function automatic logic is_motion(input logic [4:0] code);
        return (code >= CODE_HALT) && (code <= CODE_MINUS_DIR);
    endfunction

    // Motion codes that snapshot the parameter register.
    function automatic logic needs_param(input logic [4:0] code);
        return (code >= CODE_LOW_RUN) && (code <= CODE_HOME_THREE);
    endfunction

    // Protected register loads, codes 0x16 to 0x1C.
    function automatic logic is_protected(input logic [4:0] code);
        return (code >= CODE_LPOS_LOAD) && (code <= CODE_GRP2_LOAD);
    endfunction

endpackage
`default_nettype wire

/* File: rtl/ahb_reg_port.sv */
`default_nettype none
module ahb_reg_port (
    // Clock, reset and enable.
    input  wire logic                          hclk,
    input  wire logic                          hresetn,
    input  wire logic                          ce,
    // AHB-Lite slave side.
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output logic                               hreadyout,
    output logic                               hresp,
    output logic [31:0]                        hrdata,
    // Register side.
    output motion_cmd_pkg::bus_op_s            op,
    input  wire logic [31:0]                   rd_data
);
    import motion_cmd_pkg::*;

    typedef struct packed {
        bus_phase_e        phase;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       rdata;
        logic              ready;
        logic              resp;
    } port_state_s;

    port_state_s s, n;
    logic        take;
    logic        done;

    // Only whole-word single transfers occur, so the size is not decoded.
    assign take = hsel && htrans[1] && hready && (hsize == 3'h2 || hsize != 3'h2);

    // Writes finish with no wait; reads insert one wait to sample fresh data.
    always_comb begin
        n = s;
        op = '0;
        op.addr = s.addr;
        done = 1'b1;
        unique case (s.phase)
            PH_IDLE: begin
            end
            PH_WRITE: begin
                op.wr = ce;
                op.wdata = hwdata;
            end
            PH_READ: begin
                if (!s.ready) begin
                    n.rdata = rd_data;
                    n.ready = 1'b1;
                    done = 1'b0;
                end
            end
        endcase
        if (done) begin
            n.phase = PH_IDLE;
            n.ready = 1'b1;
            if (take) begin
                n.addr = haddr[ADDR_W-1:0];
                n.phase = hwrite ? PH_WRITE : PH_READ;
                n.ready = hwrite;
                op.rd = ce && !hwrite;
                // A write still in its data phase keeps its own address on the register side.
                if (!hwrite && s.phase != PH_WRITE) begin
                    op.addr = haddr[ADDR_W-1:0];
                end
            end
        end
        n.resp = 1'b0;
    end

    // Port state register, frozen while the enable is low.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '{phase: PH_IDLE, addr: '0, rdata: '0, ready: 1'b1, resp: 1'b0};
        end else if (ce) begin
            s <= n;
        end
    end

    assign hreadyout = s.ready;
    assign hresp = s.resp;
    assign hrdata = s.rdata;

endmodule
`default_nettype wire

/* File: rtl/out_port_guard.sv */
`default_nettype none
module out_port_guard (
    // Clock, reset and enable.
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       ce,
    // Output write request.
    input  wire logic       write_en,
    input  wire logic [3:0] data,
    // Pin function controls and axis state.
    input  wire logic       guard_on,
    input  wire logic       out2_axis,
    input  wire logic       moving,
    // General outputs.
    output logic [3:0]      gpo
);
    import motion_cmd_pkg::*;

    typedef struct packed {
        logic [3:0] latch;
        logic [3:0] pin;
    } guard_state_s;

    guard_state_s s, n;

    // Apply the written data, holding output 3 high under the guard while moving.
    always_comb begin
        n = s;
        if (write_en) begin
            n.latch[1:0] = data[1:0];
            if (!out2_axis) begin
                n.latch[2] = data[2];
            end
            if (guard_on && s.latch[3] && moving && !data[3]) begin
                n.latch[3] = 1'b1;
            end else begin
                n.latch[3] = data[3];
            end
        end
        n.pin = n.latch;
        if (out2_axis) begin
            n.pin[2] = moving;
        end
    end

    // Output state register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else if (ce) begin
            s <= n;
        end
    end

    assign gpo = s.pin;

endmodule
`default_nettype wire

/* File: rtl/motion_command_decoder.sv */
// Implementation choices: register access over AHB-Lite and the register offsets.
`default_nettype none
module motion_command_decoder (
    // Clock, reset and enable.
    input  wire logic                          hclk,
    input  wire logic                          hresetn,
    input  wire logic                          ce,
    // AHB-Lite slave.
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output logic                               hreadyout,
    output logic                               hresp,
    output logic [31:0]                        hrdata,
    // Axis state from the profile generator.
    input  wire logic                          axis_moving,
    // Requests to the profile generator and pattern store.
    output motion_cmd_pkg::motion_req_s        motion_req,
    output motion_cmd_pkg::profile_req_s       profile_req,
    // General outputs.
    output logic [3:0]                         gpo
);
    import motion_cmd_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] cmd;
        logic [DATA_W-1:0] staging;
        logic [DATA_W-1:0] lpos;
        logic [DATA_W-1:0] ppos;
        logic [DATA_W-1:0] strig;
        logic [DATA_W-1:0] plim;
        logic [DATA_W-1:0] mlim;
        logic [DATA_W-1:0] grp1;
        logic [DATA_W-1:0] grp2;
        logic [DATA_W-1:0] scmd;
        logic [DATA_W-1:0] param;
        logic              armed;
        logic [7:0]        answer;
        logic [7:0]        err;
        motion_req_s       motion;
        profile_req_s      profile;
    } dec_state_s;

    dec_state_s  s, n;
    bus_op_s     op;
    logic [31:0] rd_data;
    logic [4:0]  code;
    logic        cmd_wr;
    logic        out_wr;

    // Bus front end.
    ahb_reg_port u_port (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .ce        (ce),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .op        (op),
        .rd_data   (rd_data)
    );

    // General output pins with the output 3 guard and output 2 override.
    out_port_guard u_outs (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .ce        (ce),
        .write_en  (out_wr),
        .data      (op.wdata[DOP_MSB:DOP_LSB]),
        .guard_on  (s.grp1[GUARD_MSB:GUARD_LSB] != 8'h00),
        .out2_axis (s.grp2[OUT2_SEL]),
        .moving    (axis_moving),
        .gpo       (gpo)
    );

    assign code = op.wdata[CODE_MSB:CODE_LSB];
    assign cmd_wr = op.wr && (op.addr == OFS_CMD);

    // Command decode and register writes.
    always_comb begin
        n = s;
        out_wr = 1'b0;
        n.motion.start = 1'b0;
        n.profile.rd = 1'b0;
        n.profile.wr = 1'b0;
        n.profile.save = 1'b0;
        // Any transfer breaks the staging-to-load pairing.
        if (op.rd || op.wr) begin
            n.armed = 1'b0;
        end
        if (op.wr) begin
            unique case (op.addr)
                OFS_CMD: begin
                    n.cmd = '0;
                    n.cmd[CODE_MSB:CODE_LSB] = code;
                    n.cmd[SLOT_MSB:SLOT_LSB] = op.wdata[SLOT_MSB:SLOT_LSB];
                    n.cmd[DOP_MSB:DOP_LSB] = op.wdata[DOP_MSB:DOP_LSB];
                    if (code == CODE_CLEAR) begin
                        n.cmd = s.cmd;
                    end else if (is_motion(code)) begin
                        n.motion.start = 1'b1;
                        n.motion.code = code;
                        if (needs_param(code)) begin
                            n.motion.param = s.param;
                        end
                    end else if (code == CODE_OUT_WRITE) begin
                        out_wr = 1'b1;
                    end else if (is_protected(code)) begin
                        if (axis_moving) begin
                            n.answer = ANSWER_ERROR;
                            n.err = ERR_MOVING;
                        end else if (!s.armed) begin
                            n.answer = ANSWER_ERROR;
                            n.err = ERR_SEQUENCE;
                        end else begin
                            unique case (code)
                                CODE_LPOS_LOAD:  n.lpos = s.staging;
                                CODE_PPOS_LOAD:  n.ppos = s.staging;
                                CODE_STRIG_LOAD: n.strig = s.staging;
                                CODE_PLIM_LOAD:  n.plim = s.staging;
                                CODE_MLIM_LOAD:  n.mlim = s.staging;
                                CODE_GRP1_LOAD:  n.grp1 = s.staging;
                                default:         n.grp2 = s.staging;
                            endcase
                        end
                    end else if (code == CODE_SLOT_READ || code == CODE_SLOT_WRITE) begin
                        n.profile.rd = (code == CODE_SLOT_READ);
                        n.profile.wr = (code == CODE_SLOT_WRITE);
                        n.profile.slot = op.wdata[SLOT_MSB:SLOT_LSB];
                    end else if (code == CODE_FILE_SAVE) begin
                        if (axis_moving) begin
                            n.answer = ANSWER_ERROR;
                            n.err = ERR_MOVING;
                        end else begin
                            n.profile.save = 1'b1;
                        end
                    end else begin
                        n.cmd = s.cmd;
                    end
                end
                OFS_STAGE: begin
                    n.staging = op.wdata[DATA_W-1:0];
                    // A read taken in this same cycle is already the next operation.
                    n.armed = !op.rd;
                end
                OFS_SCMD: begin
                    n.scmd = '0;
                    n.scmd[SCODE_MSB:CODE_LSB] = op.wdata[SCODE_MSB:CODE_LSB];
                end
                OFS_PARAM: begin
                    n.param = op.wdata[DATA_W-1:0];
                end
                OFS_ANSWER: begin
                    n.answer = ANSWER_IDLE;
                    n.err = ERR_NONE;
                end
                default: begin
                end
            endcase
        end
    end

    // Read data for the address held in the data phase.
    always_comb begin
        rd_data = 32'h00000000;
        unique case (op.addr)
            OFS_CMD: begin
                rd_data[DATA_W-1:0] = s.cmd;
                rd_data[MOVING_BIT] = axis_moving;
            end
            OFS_AXIS:   rd_data[0] = axis_moving;
            OFS_STAGE:  rd_data[DATA_W-1:0] = s.staging;
            OFS_LPOS:   rd_data[DATA_W-1:0] = s.lpos;
            OFS_PPOS:   rd_data[DATA_W-1:0] = s.ppos;
            OFS_STRIG:  rd_data[DATA_W-1:0] = s.strig;
            OFS_PLIM:   rd_data[DATA_W-1:0] = s.plim;
            OFS_MLIM:   rd_data[DATA_W-1:0] = s.mlim;
            OFS_GRP1:   rd_data[DATA_W-1:0] = s.grp1;
            OFS_GRP2:   rd_data[DATA_W-1:0] = s.grp2;
            OFS_SCMD: begin
                rd_data[DATA_W-1:0] = s.scmd;
                rd_data[MOVING_BIT] = axis_moving;
            end
            OFS_ANSWER: begin
                rd_data[7:0] = s.answer;
                rd_data[31:ERR_LSB] = s.err;
            end
            OFS_PARAM:  rd_data[DATA_W-1:0] = s.param;
            default: begin
            end
        endcase
    end

    // Decoder state register, frozen while the enable is low.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '{cmd: REG_RESET, staging: REG_RESET, lpos: REG_RESET, ppos: REG_RESET,
                   strig: REG_RESET, plim: REG_RESET, mlim: REG_RESET, grp1: REG_RESET,
                   grp2: REG_RESET, scmd: REG_RESET, param: REG_RESET, armed: 1'b0,
                   answer: ANSWER_IDLE, err: ERR_NONE, motion: '0, profile: '0};
        end else if (ce) begin
            s <= n;
        end
    end

    assign motion_req = s.motion;
    assign profile_req = s.profile;

    // Checks on command handling.
    sequence seq_axis_read;
        (op.rd && op.addr == OFS_AXIS) ##1 ce;
    endsequence

    sequence seq_staged_load;
        (op.wr && op.addr == OFS_STAGE) ##1 (!op.rd && !op.wr)
        ##1 (cmd_wr && code == CODE_LPOS_LOAD && !axis_moving);
    endsequence

    chk_clear_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_wr && code == CODE_CLEAR |=> !motion_req.start && $stable(s.answer) && $stable(s.cmd))
        else $error("Clear command caused an action.");

    chk_motion_issue: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_wr && is_motion(code) |=> motion_req.start && motion_req.code == $past(code))
        else $error("Motion code did not start a motion request.");

    chk_param_capture: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_wr && needs_param(code) |=> motion_req.param == $past(s.param))
        else $error("Motion parameter not captured at issue.");

    chk_out_write: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_wr && code == CODE_OUT_WRITE |=> gpo[1:0] == $past(op.wdata[DOP_LSB+1:DOP_LSB]))
        else $error("Output write data not applied.");

    chk_out3_guard: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_wr && code == CODE_OUT_WRITE && s.grp1[GUARD_MSB:GUARD_LSB] != 8'h00 && gpo[3]
        && axis_moving && !op.wdata[DOP_MSB] |=> gpo[3])
        else $error("Guarded output 3 cleared while moving.");

    chk_out2_override: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && s.grp2[OUT2_SEL] && $stable(s.grp2) |=> gpo[2] == $past(axis_moving))
        else $error("Output 2 not following axis state.");

    chk_axis_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        seq_axis_read |=> hreadyout && hrdata[0] == $past(axis_moving))
        else $error("Axis state read shows wrong motion flag.");

    chk_staged_load: assert property (@(posedge hclk) disable iff (!hresetn)
        seq_staged_load |=> s.lpos == $past(s.staging) && s.answer == $past(s.answer))
        else $error("Staged protected load not applied.");

    chk_moving_reject: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_wr && is_protected(code) && axis_moving
        |=> s.answer == ANSWER_ERROR && s.err == ERR_MOVING && $stable(s.lpos) && $stable(s.grp2))
        else $error("Protected load while moving not rejected.");

    chk_unstaged_reject: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_wr && is_protected(code) && !axis_moving && !s.armed
        |=> s.answer == ANSWER_ERROR && s.err == ERR_SEQUENCE && $stable(s.ppos))
        else $error("Unstaged protected load not rejected.");

    chk_slot_number: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_wr && code == CODE_SLOT_READ |=> profile_req.rd && profile_req.slot == $past(op.wdata[SLOT_MSB:SLOT_LSB]))
        else $error("Slot read request or number wrong.");

    chk_reserved_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_wr && code > CODE_OUT_WRITE && code < CODE_LPOS_LOAD
        |=> !motion_req.start && !profile_req.rd && !profile_req.wr && !profile_req.save && $stable(s.answer))
        else $error("Reserved code caused an action.");

endmodule
`default_nettype wire

/* File: test/axis_model.sv */
`default_nettype none
module axis_model #(
    parameter int RUN_LEN = 40
) (
    // Clock and reset.
    input  wire logic                        hclk,
    input  wire logic                        hresetn,
    // Decoder request and axis state.
    input  wire motion_cmd_pkg::motion_req_s motion_req,
    output logic                             axis_moving
);
    import motion_cmd_pkg::*;
    int left;
    // A motion start runs the axis for a while; a halt stops it at once.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            left <= 0;
        end else if (motion_req.start && motion_req.code != CODE_HALT) begin
            left <= RUN_LEN;
        end else if (motion_req.start || left == 0) begin
            left <= 0;
        end else begin
            left <= left - 1;
        end
    end
    assign axis_moving = (left != 0);
endmodule
`default_nettype wire

/* File: test/tb_motion_command_decoder.sv */
`default_nettype none
module tb_motion_command_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    import motion_cmd_pkg::*;
    logic         hclk = 0, hresetn = 0, ce = 1, hsel = 0, hwrite = 0, hreadyout, hresp, axis_moving;
    logic [1:0]   htrans = 0;
    logic [2:0]   hsize = 0;
    logic [31:0]  haddr = 0, hwdata = 0, hrdata, r;
    logic [3:0]   gpo;
    logic [4:0]   m_code;
    logic [23:0]  m_param;
    motion_req_s  motion_req;
    profile_req_s profile_req;
    int           err_count = 0, samples_checked = 0, n_pm = 0;
    motion_command_decoder dut (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .axis_moving, .motion_req, .profile_req, .gpo);
    axis_model axis (.hclk, .hresetn, .motion_req, .axis_moving);
    // Clock and a record of the one-cycle request pulses.
    always #10 hclk = ~hclk;
    always @(posedge hclk) begin
        if (motion_req.start === 1'b1) begin
            m_code <= motion_req.code;
            m_param <= motion_req.param;
        end
        if ((profile_req.rd | profile_req.wr | profile_req.save) === 1'b1) begin
            n_pm <= n_pm + 1;
        end
    end
    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Single word transfer; waits on hready in both phases, bounded.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'b010;
        haddr <= {24'h000000, a};
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            err_count++;
            end_sim();
        end
        htrans <= 2'b00;
        hwdata <= d;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
        r = hrdata;
        if (hreadyout !== 1'b1) begin
            err_count++;
            end_sim();
        end
    endtask
    function automatic logic [31:0] cw(input logic [4:0] c, input logic [4:0] s, input logic [3:0] d);
        return {11'h000, c, 3'h0, s, d, 4'h0};
    endfunction
    task automatic cmd(input logic [4:0] c, input logic [4:0] s, input logic [3:0] d);
        xfer(1'b1, OFS_CMD, cw(c, s, d));
    endtask
    task automatic t_outputs();
        xfer(1'b0, OFS_CMD, 32'h0);
        chk(r, 32'h0);
        cmd(CODE_CLEAR, 5'h00, 4'hF);
        @(posedge hclk);
        chk(32'(gpo), 32'h0);
        cmd(CODE_OUT_WRITE, 5'h00, 4'hA);
        @(posedge hclk);
        chk(32'(gpo), 32'hA);
    endtask
    task automatic t_protected();
        xfer(1'b1, OFS_STAGE, 32'h123456);
        cmd(CODE_LPOS_LOAD, 5'h00, 4'h0);
        xfer(1'b0, OFS_LPOS, 32'h0);
        chk(r, 32'h123456);
        xfer(1'b1, OFS_STAGE, 32'h000055);
        xfer(1'b0, OFS_AXIS, 32'h0);
        chk(r, 32'h0);
        cmd(CODE_PPOS_LOAD, 5'h00, 4'h0);
        xfer(1'b0, OFS_ANSWER, 32'h0);
        chk(r, {ERR_SEQUENCE, 16'h0000, ANSWER_ERROR});
        xfer(1'b0, OFS_PPOS, 32'h0);
        chk(r, 32'h0);
        xfer(1'b1, OFS_ANSWER, 32'h0);
    endtask
    task automatic t_motion();
        xfer(1'b1, OFS_PARAM, 32'h00ABCD);
        cmd(5'h0C, 5'h00, 4'h0);
        xfer(1'b1, OFS_PARAM, 32'h000777);
        chk({m_param, 3'h0, m_code}, {24'h00ABCD, 8'h0C});
        xfer(1'b0, OFS_CMD, 32'h0);
        chk(32'(r[MOVING_BIT]), 32'h1);
        xfer(1'b0, OFS_SCMD, 32'h0);
        chk(32'(r[MOVING_BIT]), 32'h1);
        xfer(1'b1, OFS_STAGE, 32'h000001);
        cmd(CODE_GRP1_LOAD, 5'h00, 4'h0);
        xfer(1'b0, OFS_ANSWER, 32'h0);
        chk(r, {ERR_MOVING, 16'h0000, ANSWER_ERROR});
        xfer(1'b1, OFS_ANSWER, 32'h0);
        cmd(CODE_HALT, 5'h00, 4'h0);
    endtask
    task automatic t_guard();
        xfer(1'b1, OFS_STAGE, 32'h000001);
        cmd(CODE_GRP1_LOAD, 5'h00, 4'h0);
        cmd(CODE_OUT_WRITE, 5'h00, 4'h8);
        cmd(CODE_LOW_RUN, 5'h00, 4'h0);
        cmd(CODE_OUT_WRITE, 5'h00, 4'h0);
        @(posedge hclk);
        chk(32'(gpo), 32'h8);
        cmd(CODE_HALT, 5'h00, 4'h0);
        xfer(1'b1, OFS_STAGE, 32'h000001);
        cmd(CODE_GRP2_LOAD, 5'h00, 4'h0);
        cmd(CODE_OUT_WRITE, 5'h00, 4'h4);
        @(posedge hclk);
        chk(32'(gpo), 32'h0);
    endtask
    task automatic t_reserved_slot();
        cmd(5'h13, 5'h00, 4'hF);
        xfer(1'b0, OFS_CMD, 32'h0);
        chk(r, cw(CODE_OUT_WRITE, 5'h00, 4'h4));
        chk(32'(gpo), 32'h0);
        for (int c = 0; c < 3; c++) begin
            cmd(5'(CODE_SLOT_READ + c), 5'(5'h11 + c), 4'h0);
        end
        repeat (2) @(posedge hclk);
        chk({n_pm[15:0], 11'h0, profile_req.slot}, {16'h3, 16'h12});
    endtask
    // Reset for two cycles, then run each scenario in turn.
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_outputs();
        t_protected();
        t_motion();
        t_guard();
        t_reserved_slot();
        end_sim();
    end
endmodule
`default_nettype wire
